// ==== src/ssrx_top.sv ====
// The AXI4-Lite slave port and the register addresses were decided locally.
module ssrx_top (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        clock_line_in,
	output logic             clock_line_out,
	output logic             clock_line_oe,
	input  wire logic        data_line_in,
	output logic             data_line_out,
	output logic             data_line_oe,
	output logic             receive_flag
);
	import ssrx_pkg::*;

	// =========================================================
	// Configuration registers
	logic [7:0]  txctl_reg;
	logic [7:0]  baud_reg;
	logic [15:0] brg_reg;
	logic        port_en_reg;
	logic        nine_reg;
	logic        single_en_reg;
	logic        cont_en_reg;
	logic        cont_prev_reg;
	logic        overrun_reg;
	logic        overrun_single_reg;
	logic        sync_on;
	logic        is_master;
	logic        idle_pol;
	logic        master_rx;
	logic        slave_rx;
	logic        run_m;
	logic        run_s;

	assign sync_on   = port_en_reg && txctl_reg[SYNC_BIT];
	assign is_master = txctl_reg[MASTER_BIT];
	assign idle_pol  = baud_reg[POL_BIT];
	assign master_rx = sync_on && is_master && (single_en_reg || cont_en_reg);
	assign slave_rx  = sync_on && !is_master && cont_en_reg;
	assign run_m     = master_rx && !overrun_reg;
	assign run_s     = slave_rx && !overrun_reg;

	// =========================================================
	// Bus slave
	logic        aw_hold_reg;
	logic        w_hold_reg;
	logic [7:0]  awaddr_reg;
	logic [31:0] wdata_reg;
	logic        wlane_reg;
	logic        wr_go;
	logic        rd_go;
	logic        pop;

	assign wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;

	function automatic logic known_ofs(input logic [7:0] a);
		known_ofs = (a[1:0] == 2'h0) && (a <= STAT_OFS);
	endfunction

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg  <= 1'b0;
			awaddr_reg  <= REG8_RST;
			wdata_reg   <= '0;
			wlane_reg   <= 1'b0;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_hold_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wlane_reg  <= s_axi_wstrb[0];
			end else if (wr_go) begin
				w_hold_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else if (clk_en) begin
			s_axi_awready <= !aw_hold_reg && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_hold_reg && !(s_axi_wvalid && s_axi_wready);
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= known_ofs(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// =========================================================
	// Receive FIFO, two entries of nine bits
	logic [8:0] fifo_mem [2];
	logic       wr_ptr_reg;
	logic       rd_ptr_reg;
	logic [1:0] count_reg;
	logic [1:0] count_next;
	logic [8:0] head;
	logic       push;
	logic       done;

	assign head = fifo_mem[rd_ptr_reg];
	assign pop  = rd_go && (s_axi_araddr == RXDATA_OFS) && (count_reg != 2'h0);
	assign push = done && (count_reg != FIFO_FULL);

	always_comb begin
		count_next = count_reg;
		if (!port_en_reg) begin
			count_next = 2'h0;
		end else if (push && !pop) begin
			count_next = count_reg + 2'h1;
		end else if (pop && !push) begin
			count_next = count_reg - 2'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			wr_ptr_reg   <= 1'b0;
			rd_ptr_reg   <= 1'b0;
			count_reg    <= 2'h0;
			receive_flag <= 1'b0;
		end else if (clk_en) begin
			count_reg    <= count_next;
			receive_flag <= (count_next != 2'h0);
			if (!port_en_reg) begin
				wr_ptr_reg <= 1'b0;
				rd_ptr_reg <= 1'b0;
			end else begin
				if (push) begin
					wr_ptr_reg <= !wr_ptr_reg;
				end
				if (pop) begin
					rd_ptr_reg <= !rd_ptr_reg;
				end
			end
		end
	end

	// =========================================================
	// Read path
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (clk_en) begin
			s_axi_arready <= !s_axi_rvalid && !rd_go;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= known_ofs(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
				unique case (s_axi_araddr)
					TXCTL_OFS:  s_axi_rdata <= {24'h0, txctl_reg};
					RXCTL_OFS:  s_axi_rdata <= {24'h0, port_en_reg, nine_reg, single_en_reg,
						cont_en_reg, 2'h0, overrun_reg, head[8]};
					BAUD_OFS:   s_axi_rdata <= {24'h0, baud_reg};
					RXDATA_OFS: s_axi_rdata <= {24'h0, head[7:0]};
					DIVL_OFS:   s_axi_rdata <= {24'h0, brg_reg[7:0]};
					DIVH_OFS:   s_axi_rdata <= {24'h0, brg_reg[15:8]};
					STAT_OFS:   s_axi_rdata <= {30'h0, overrun_reg, receive_flag};
					default:    s_axi_rdata <= '0;
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// =========================================================
	// Software registers; hardware clears single enable
	logic wr_low;
	assign wr_low = wr_go && wlane_reg;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			txctl_reg     <= REG8_RST;
			baud_reg      <= REG8_RST;
			brg_reg       <= '0;
			port_en_reg   <= 1'b0;
			nine_reg      <= 1'b0;
			single_en_reg <= 1'b0;
			cont_en_reg   <= 1'b0;
		end else if (clk_en) begin
			if (done && is_master) begin
				single_en_reg <= 1'b0;
			end
			if (wr_low) begin
				unique case (awaddr_reg)
					TXCTL_OFS: txctl_reg <= wdata_reg[7:0];
					BAUD_OFS:  baud_reg <= wdata_reg[7:0];
					DIVL_OFS:  brg_reg[7:0] <= wdata_reg[7:0];
					DIVH_OFS:  brg_reg[15:8] <= wdata_reg[7:0];
					RXCTL_OFS: begin
						port_en_reg   <= wdata_reg[PORT_EN_BIT];
						nine_reg      <= wdata_reg[NINE_BIT];
						single_en_reg <= wdata_reg[SINGLE_BIT];
						cont_en_reg   <= wdata_reg[CONT_BIT];
					end
					default: begin
					end
				endcase
			end
		end
	end

	// =========================================================
	// Overrun; a new overrun wins over any clear in that cycle
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			overrun_reg        <= 1'b0;
			overrun_single_reg <= 1'b0;
			cont_prev_reg      <= 1'b0;
		end else if (clk_en) begin
			cont_prev_reg <= cont_en_reg;
			if (done && count_reg == FIFO_FULL) begin
				overrun_reg        <= 1'b1;
				overrun_single_reg <= single_en_reg && !cont_en_reg;
			end else if (!port_en_reg || (cont_prev_reg && !cont_en_reg)) begin
				overrun_reg <= 1'b0;
			end else if (pop && overrun_single_reg) begin
				overrun_reg <= 1'b0;
			end
		end
	end

	// =========================================================
	// Pin synchronisers
	logic ck_s1_reg;
	logic ck_s2_reg;
	logic ck_s3_reg;
	logic dt_s1_reg;
	logic dt_s2_reg;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ck_s1_reg <= 1'b0;
			ck_s2_reg <= 1'b0;
			ck_s3_reg <= 1'b0;
			dt_s1_reg <= 1'b0;
			dt_s2_reg <= 1'b0;
		end else if (clk_en) begin
			ck_s1_reg <= clock_line_in;
			ck_s2_reg <= ck_s1_reg;
			ck_s3_reg <= ck_s2_reg;
			dt_s1_reg <= data_line_in;
			dt_s2_reg <= dt_s1_reg;
		end
	end

	// =========================================================
	// Bit clock and shifter
	logic [15:0] brg_cnt_reg;
	logic [3:0]  bitcnt_reg;
	logic [8:0]  shift_reg;
	logic        tick;
	logic        trail_m;
	logic        trail_s;
	logic        samp;
	logic [3:0]  nbits;

	assign nbits   = nine_reg ? CHAR9_BITS : CHAR8_BITS;
	assign tick    = run_m && (brg_cnt_reg == 16'h0);
	assign trail_m = tick && (clock_line_out != idle_pol);
	assign trail_s = run_s && (ck_s3_reg != idle_pol) && (ck_s2_reg == idle_pol);
	assign samp    = trail_m || trail_s;
	assign done    = samp && (bitcnt_reg == nbits - 4'h1);

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			brg_cnt_reg    <= '0;
			clock_line_out <= 1'b0;
			bitcnt_reg     <= 4'h0;
			shift_reg      <= '0;
		end else if (clk_en) begin
			if (!run_m && !run_s) begin
				// Abort drops partial bits; clock parks at once
				brg_cnt_reg    <= brg_reg;
				clock_line_out <= idle_pol;
				bitcnt_reg     <= 4'h0;
			end else begin
				if (run_m) begin
					brg_cnt_reg <= tick ? brg_reg : brg_cnt_reg - 16'h1;
					if (tick) begin
						clock_line_out <= !clock_line_out;
					end
				end
				if (samp) begin
					shift_reg[bitcnt_reg] <= dt_s2_reg;
					bitcnt_reg <= done ? 4'h0 : bitcnt_reg + 4'h1;
				end
			end
		end
	end

	// Last bit bypasses shift_reg, which updates one edge late
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			fifo_mem[0] <= '0;
			fifo_mem[1] <= '0;
		end else if (clk_en && push) begin
			fifo_mem[wr_ptr_reg] <= nine_reg ? {dt_s2_reg, shift_reg[7:0]}
				: {1'b0, dt_s2_reg, shift_reg[6:0]};
		end
	end

	// =========================================================
	// Pin drivers; transmit shifting is not part of this block
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			clock_line_oe <= 1'b0;
			data_line_oe  <= 1'b0;
			data_line_out <= 1'b0;
		end else if (clk_en) begin
			clock_line_oe <= sync_on && is_master;
			data_line_oe  <= sync_on && !single_en_reg && !cont_en_reg;
			data_line_out <= 1'b0;
		end
	end

	// =========================================================
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn || !clk_en);

	dt_rx_off_a: assert property (master_rx |=> !data_line_oe)
		else $error("data line driven in master receive");
	ck_slave_off_a: assert property ((sync_on && !is_master) |=> !clock_line_oe)
		else $error("clock line driven in slave mode");
	ck_master_on_a: assert property ((sync_on && is_master) |=> clock_line_oe)
		else $error("master not driving clock");
	single_clear_a: assert property ((done && is_master && !wr_low) |=> !single_en_reg)
		else $error("single enable not cleared");
	flag_level_a: assert property (receive_flag == (count_reg != 2'h0))
		else $error("receive flag disagrees with fifo");
	ovr_keep_a: assert property ((done && count_reg == FIFO_FULL && !pop && port_en_reg)
		|=> overrun_reg && count_reg == FIFO_FULL)
		else $error("overrun not flagged or data lost");
	abort_park_a: assert property (($fell(cont_en_reg) && !single_en_reg && is_master)
		|=> bitcnt_reg == 4'h0 && clock_line_out == $past(idle_pol))
		else $error("abort did not park clock");
	push_count_a: assert property ((push && !pop && port_en_reg)
		|=> count_reg == $past(count_reg) + 2'h1)
		else $error("character not stored");
	ovr_block_a: assert property ((overrun_reg && port_en_reg && !pop)
		|=> count_reg == $past(count_reg))
		else $error("reception while overrun");

	single_char_c: cover property (is_master && single_en_reg && !cont_en_reg ##[1:400] done);
	fifo_full_c: cover property (count_reg == FIFO_FULL);
	overrun_c: cover property ($rose(overrun_reg));
	slave_char_c: cover property (trail_s && done);
endmodule

// ==== inc/ssrx_pkg.sv ====
// Operation
// - Master receive releases the data line
// - Either receive enable starts master reception
// - Single receive clocks exactly one character
// - Single enable self-clears after one character
// - Continuous enable clocks until software clears
// - Clearing continuous mid-character aborts and discards
// - Both enables: single clears, continuous continues
// - Sample data on each trailing clock edge
// - Full character sets flag, enters FIFO
// - Data register shows oldest entry low byte
// - Flag stays set while FIFO non-empty
// - Slave mode releases clock line, uses peer
// - Third character sets overrun, keeps entries
// - Overrun blocks reception, stored data readable
// - Single-mode overrun cleared by data read
// - Continuous overrun cleared by enable or port
// - Nine-bit mode exposes ninth bit of head
// - Sync, slave, port enable selects slave
// - Slave: enables clear means transmit direction
// - Master drives its bit clock out
// - Polarity bit sets idle level and edges
// - Slave receive ignores the single enable
package ssrx_pkg;
	// =========================================================
	// Register map
	localparam logic [7:0] TXCTL_OFS  = 8'h00;
	localparam logic [7:0] RXCTL_OFS  = 8'h04;
	localparam logic [7:0] BAUD_OFS   = 8'h08;
	localparam logic [7:0] RXDATA_OFS = 8'h0c;
	localparam logic [7:0] DIVL_OFS   = 8'h10;
	localparam logic [7:0] DIVH_OFS   = 8'h14;
	localparam logic [7:0] TXDATA_OFS = 8'h18;
	localparam logic [7:0] STAT_OFS   = 8'h1c;
	// =========================================================
	// Field positions
	localparam int MASTER_BIT  = 7;
	localparam int SYNC_BIT    = 4;
	localparam int PORT_EN_BIT = 7;
	localparam int NINE_BIT    = 6;
	localparam int SINGLE_BIT  = 5;
	localparam int CONT_BIT    = 4;
	localparam int POL_BIT     = 4;
	// =========================================================
	// Reset values, answers and sizes
	localparam logic [7:0] REG8_RST   = 8'h00;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [3:0] CHAR8_BITS = 4'h8;
	localparam logic [3:0] CHAR9_BITS = 4'h9;
	localparam logic [1:0] FIFO_FULL  = 2'h2;
endpackage

// ==== verification/ssrx_peer.sv ====
module ssrx_peer (
	input  wire logic dev_clk,
	input  wire logic dev_drv,
	input  wire logic idle_pol,
	output logic      peer_clk,
	output logic      peer_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] q[$];
	logic [8:0] cur;
	int         nb;
	int         idx;
	initial begin
		peer_clk = 1'b0;
		peer_data = 1'b0;
		cur = 9'h000;
		nb = 8;
		idx = 0;
	end
	// =========================================================
	// Slave side of a device-clocked transfer
	task automatic load(input logic [8:0] w0, input logic [8:0] w1, input logic [8:0] w2,
		input int n);
		q = '{w0, w1, w2};
		nb = n;
		idx = 0;
	endtask
	// Leading edge: next bit out, LSB first; after the last bit the line stops holding
	always @(dev_clk) begin
		if (dev_drv === 1'b1 && dev_clk !== idle_pol) begin
			if (idx == 0)
				cur = (q.size() > 0) ? q.pop_front() : ~cur;
			peer_data <= cur[idx];
			idx = (idx + 1) % nb;
		end else if (dev_drv === 1'b1 && idx == 0) begin
			peer_data <= #24 ~cur[nb-1];
		end
	end
	// =========================================================
	// Clock master for a slave device
	task automatic frame(input logic [8:0] w, input int n);
		// Keep every line change off the device clock edges
		#2;
		for (int i = 0; i < n; i++) begin
			peer_clk = ~idle_pol;
			peer_data = w[i];
			#80;
			peer_clk = idle_pol;
			#80;
		end
		peer_data = ~w[n-1];
	endtask
endmodule

// ==== verification/sync_serial_master_rx_slave_cfg_tb.sv ====
module sync_serial_master_rx_slave_cfg_tb;
	import ssrx_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk, resetn, pol, clk_prev;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, div;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, receive_flag;
	logic        clock_line_in, clock_line_out, clock_line_oe;
	logic        data_line_in, data_line_out, data_line_oe, peer_clk, peer_data;
	logic [8:0]  w [3];
	int          error_cnt, checked, lead_cnt;
	ssrx_top DUT (.ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'h1),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.clock_line_in(clock_line_in), .clock_line_out(clock_line_out),
		.clock_line_oe(clock_line_oe), .data_line_in(data_line_in),
		.data_line_out(data_line_out), .data_line_oe(data_line_oe),
		.receive_flag(receive_flag));
	ssrx_peer PEER (.dev_clk(clock_line_in), .dev_drv(clock_line_oe), .idle_pol(pol),
		.peer_clk(peer_clk), .peer_data(peer_data));
	// Whoever enables its driver owns the wire
	assign clock_line_in = clock_line_oe ? clock_line_out : peer_clk;
	assign data_line_in = data_line_oe ? data_line_out : peer_data;
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// Counts leading edges of the clock the device drives
	always @(posedge ref_clk) begin
		if (clock_line_oe === 1'b1 && clk_prev === pol && clock_line_out !== pol)
			lead_cnt++;
		clk_prev = clock_line_out;
	end
	// =========================================================
	// Bus and check tasks
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] v);
		logic aw, wd;
		int   n;
		aw = 1'b0;
		wd = 1'b0;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {24'h000000, v};
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && wd) && n < 100) begin
			@(posedge ref_clk);
			n++;
			if (s_axi_awready === 1'b1)
				aw = 1'b1;
			if (s_axi_wready === 1'b1)
				wd = 1'b1;
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (wd)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1 && n < 100) begin
			@(posedge ref_clk);
			n++;
		end
		s_axi_bready <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic axi_rd(input logic [7:0] a);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (s_axi_arready !== 1'b1 && n < 100);
		s_axi_arvalid <= 1'b0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < 100);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		axi_rd(a);
		chk(d, exp);
	endtask
	task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		int n;
		n = 0;
		do begin
			axi_rd(a);
			n++;
		end while ((d & m) !== v && n < 500);
	endtask
	function automatic logic [31:0] rc_val(input logic nine, input logic continuous_receive_enable, input logic ovr,
		input logic r9d);
		return {24'h000000, 1'b1, nine, 1'b0, continuous_receive_enable, 2'b00, ovr, r9d};
	endfunction
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// =========================================================
	// Tests
	initial begin
		#200000;
		error_cnt++;
		print_verdict;
	end
	initial begin
		resetn = 1'b0;
		pol = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		void'($urandom(58));
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge ref_clk);
		for (int a = 0; a < 32; a += 4)
			rdchk(8'(a), {24'h000000, REG8_RST});
		rdchk(8'h20, 32'h0);
		chk(r, RESP_SLVERR);
		rdchk(8'h02, 32'h0);
		chk(r, RESP_SLVERR);
		div = 8'($urandom);
		axi_wr(DIVH_OFS, div);
		rdchk(DIVH_OFS, {24'h000000, div});
		$display("test registers done");
		for (int p = 0; p < 2; p++) begin
			pol = p[0];
			div = 8'($urandom_range(6, 3));
			w[0] = 9'($urandom);
			axi_wr(DIVH_OFS, 8'h00);
			axi_wr(DIVL_OFS, div);
			axi_wr(BAUD_OFS, {3'b000, pol, 4'h0});
			axi_wr(TXCTL_OFS, 8'h90);
			axi_wr(RXCTL_OFS, 8'h80);
			PEER.load(w[0], 9'h0, 9'h0, 8);
			lead_cnt = 0;
			chk(clock_line_out, pol);
			axi_wr(RXCTL_OFS, 8'ha0);
			chk(data_line_oe, 1'b0);
			poll(STAT_OFS, 32'h1, 32'h1);
			repeat (40) @(posedge ref_clk);
			chk(lead_cnt, 8);
			chk({clock_line_oe, data_line_oe, clock_line_out}, {2'b11, pol});
			rdchk(RXCTL_OFS, rc_val(0, 0, 0, 0));
			chk(receive_flag, 1'b1);
			rdchk(RXDATA_OFS, {24'h000000, w[0][7:0]});
			rdchk(STAT_OFS, 32'h0);
		end
		$display("test master single done");
		for (int i = 0; i < 3; i++)
			w[i] = 9'($urandom);
		PEER.load(w[0], w[1], w[2], 9);
		lead_cnt = 0;
		axi_wr(RXCTL_OFS, 8'hf0);
		poll(STAT_OFS, 32'h1, 32'h1);
		axi_rd(RXCTL_OFS);
		chk(d & 32'h30, 32'h10);
		poll(STAT_OFS, 32'h2, 32'h2);
		repeat (100) @(posedge ref_clk);
		chk(lead_cnt, 27);
		rdchk(RXCTL_OFS, rc_val(1, 1, 1, w[0][8]));
		rdchk(RXDATA_OFS, {24'h000000, w[0][7:0]});
		rdchk(RXCTL_OFS, rc_val(1, 1, 1, w[1][8]));
		rdchk(RXDATA_OFS, {24'h000000, w[1][7:0]});
		rdchk(STAT_OFS, 32'h2);
		axi_wr(RXCTL_OFS, 8'hc0);
		axi_rd(RXCTL_OFS);
		chk(d & 32'h2, 32'h0);
		$display("test continuous overrun done");
		axi_wr(RXCTL_OFS, 8'h80);
		PEER.load(9'($urandom), 9'h0, 9'h0, 8);
		lead_cnt = 0;
		axi_wr(RXCTL_OFS, 8'h90);
		for (int n = 0; n < 500 && lead_cnt < 3; n++)
			@(posedge ref_clk);
		axi_wr(RXCTL_OFS, 8'h80);
		repeat (4) @(posedge ref_clk);
		chk(clock_line_out, pol);
		repeat (100) @(posedge ref_clk);
		rdchk(STAT_OFS, 32'h0);
		PEER.load(w[2], w[1], w[0], 8);
		for (int i = 0; i < 3; i++) begin
			axi_wr(RXCTL_OFS, 8'ha0);
			poll(RXCTL_OFS, 32'h20, 32'h0);
		end
		rdchk(RXCTL_OFS, rc_val(0, 0, 1, 0));
		rdchk(RXDATA_OFS, {24'h000000, w[2][7:0]});
		rdchk(RXCTL_OFS, rc_val(0, 0, 0, 0));
		rdchk(RXDATA_OFS, {24'h000000, w[1][7:0]});
		$display("test abort and single overrun done");
		pol = 1'b0;
		axi_wr(RXCTL_OFS, 8'h00);
		axi_wr(BAUD_OFS, 8'h00);
		axi_wr(TXCTL_OFS, 8'h10);
		axi_wr(RXCTL_OFS, 8'h80);
		repeat (4) @(posedge ref_clk);
		chk({clock_line_oe, data_line_oe}, 2'b01);
		axi_wr(RXCTL_OFS, 8'ha0);
		PEER.frame(9'($urandom), 8);
		repeat (20) @(posedge ref_clk);
		chk({data_line_oe, receive_flag}, 2'b00);
		axi_wr(RXCTL_OFS, 8'h90);
		PEER.frame(w[0], 8);
		poll(STAT_OFS, 32'h1, 32'h1);
		rdchk(RXDATA_OFS, {24'h000000, w[0][7:0]});
		$display("test slave receive done");
		print_verdict;
	end
endmodule
